// ===== verilog/psbrg_regs.svh
/*
 constants of the partition space bridge: label encodings, field layout.
 assumes inclusion by its bare name from the bridge's design files.
*/
`ifndef PSBRG_REGS_SVH
`define PSBRG_REGS_SVH
// ==========================================================
// label encodings
`define PSBRG_SP_SECURE     2'h0
`define PSBRG_SP_NONSECURE  2'h1
`define PSBRG_SP_ROOT       2'h2
`define PSBRG_SP_REALM      2'h3
`define PSBRG_NS_SECURE     1'h0
`define PSBRG_NS_NONSECURE  1'h1
// ==========================================================
// widths and reset values
`define PSBRG_ADDR_W        48
`define PSBRG_PAS_W         2
`define PSBRG_PARTID_W      16
`define PSBRG_PMG_W         8
`define PSBRG_USER_W        8
`define PSBRG_MAP_ROOT_NS_RST  1'h0
`define PSBRG_MAP_REALM_NS_RST 1'h1
`endif

// ===== verilog/psbrg_pkg.sv
/*
 types shared by the partition space bridge modules.
 assumes psbrg_regs.svh sits on the include path.
*/
`include "psbrg_regs.svh"
package psbrg_pkg;
	// ==========================================================
	// partition space labels
	typedef logic [1:0] psbrg_sp_t;
	typedef logic       psbrg_ns_t;
endpackage

// ===== verilog/psbrg_reduce.sv
/*
 combinational reduction of a 2-bit space label to a 1-bit label.
 assumes the caller registers the result; map bits are static per request.
*/
`timescale 1ns/1ps
`include "psbrg_regs.svh"
module psbrg_reduce (
	// four-space label in
	input  wire psbrg_pkg::psbrg_sp_t sp_in,
	// programmable choice for root and realm
	input  wire logic                 prog_en,
	input  wire logic                 map_root_ns,
	input  wire logic                 map_realm_ns,
	// two-space label out
	output      psbrg_pkg::psbrg_ns_t ns_out
);
	always_comb begin
		case (sp_in)
			`PSBRG_SP_SECURE:    ns_out = `PSBRG_NS_SECURE;
			`PSBRG_SP_NONSECURE: ns_out = `PSBRG_NS_NONSECURE;
			// fixed reduction keeps only bit zero
			`PSBRG_SP_ROOT:      ns_out = prog_en ? map_root_ns
			                                      : `PSBRG_NS_SECURE;
			`PSBRG_SP_REALM:     ns_out = prog_en ? map_realm_ns
			                                      : `PSBRG_NS_NONSECURE;
			default:             ns_out = `PSBRG_NS_SECURE;
		endcase
	end
endmodule

// ===== verilog/psbrg_bridge.sv
/*
 partition space bridge: a two-to-four expansion path, a four-to-two
 reduction path and a control access filter, each one register stage.
 both paths run side by side and never stall: a request on either
 input shows on the matching output one clock later, for one clock.
 assumes a single clock, requesters that pick labels correctly, map
 bits that stay put while requests use them, address space codes
 that follow the label codes one to one, and far sides that take one
 request per clock, since there is no ready signal.
*/
`timescale 1ns/1ps
`include "psbrg_regs.svh"
// Summary of operation
// - two-bit label: secure, nonsecure, root, realm
// - expand zero to secure, one to nonsecure
// - physical address space passes unchanged
// - secure label never becomes another space
// - nonsecure label never becomes another space
// - full two-bit label forwarded in four-space
// - expansion path always emits two-bit label
// - reduce to one bit, fixed or programmable
// - requester picks space from state, level
// - two-space completer sees only two spaces
// - control access only in matching address space
// - fixed reduction keeps label bit zero
module psbrg_bridge #(
	parameter int ADDR_W   = `PSBRG_ADDR_W,
	parameter int PARTID_W = `PSBRG_PARTID_W,
	parameter int PMG_W    = `PSBRG_PMG_W,
	parameter int USER_W   = `PSBRG_USER_W
) (
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  resetn,
	// mapping control
	input  wire logic                  prog_en,
	input  wire logic                  map_root_ns,
	input  wire logic                  map_realm_ns,
	// expansion path in, from two-space requester
	input  wire logic                  exp_valid,
	input  wire logic [ADDR_W-1:0]     exp_addr,
	input  wire logic [`PSBRG_PAS_W-1:0] exp_pas,
	input  wire psbrg_pkg::psbrg_ns_t  exp_space_label_1bit,
	input  wire logic [PARTID_W-1:0]   exp_partid,
	input  wire logic [PMG_W-1:0]      exp_pmg,
	input  wire logic [USER_W-1:0]     exp_user,
	// expansion path out, into four-space region
	output      logic                  exo_valid,
	output      logic [ADDR_W-1:0]     exo_addr,
	output      logic [`PSBRG_PAS_W-1:0] exo_pas,
	output      psbrg_pkg::psbrg_sp_t  exo_space_label_2bit,
	output      logic [PARTID_W-1:0]   exo_partid,
	output      logic [PMG_W-1:0]      exo_pmg,
	output      logic [USER_W-1:0]     exo_user,
	// reduction path in, from four-space region
	input  wire logic                  red_valid,
	input  wire logic [ADDR_W-1:0]     red_addr,
	input  wire logic [`PSBRG_PAS_W-1:0] red_pas,
	input  wire psbrg_pkg::psbrg_sp_t  red_space_label_2bit,
	input  wire logic [PARTID_W-1:0]   red_partid,
	input  wire logic [PMG_W-1:0]      red_pmg,
	input  wire logic [USER_W-1:0]     red_user,
	input  wire logic                  red_ctl_access,
	// reduction path out, to two-space completer
	output      logic                  rdo_valid,
	output      logic [ADDR_W-1:0]     rdo_addr,
	output      logic [`PSBRG_PAS_W-1:0] rdo_pas,
	output      psbrg_pkg::psbrg_ns_t  rdo_space_label_1bit,
	output      logic [PARTID_W-1:0]   rdo_partid,
	output      logic [PMG_W-1:0]      rdo_pmg,
	output      logic [USER_W-1:0]     rdo_user,
	output      logic                  rdo_ctl_ok
);
	// ==========================================================
	// state
	// one register stage per path; the paths share only the clock and reset,
	// so a request on one never waits for the other. valid bits alone
	// mark a request, the fields behind them keep their last value, except ctl_ok, which clears
	typedef struct packed {
		logic                    valid;
		logic [ADDR_W-1:0]       addr;
		logic [`PSBRG_PAS_W-1:0] pas;
		logic [1:0]              sp;
		logic [PARTID_W-1:0]     partid;
		logic [PMG_W-1:0]        pmg;
		logic [USER_W-1:0]       user;
	} psbrg_exp_t;

	typedef struct packed {
		logic                    valid;
		logic [ADDR_W-1:0]       addr;
		logic [`PSBRG_PAS_W-1:0] pas;
		logic                    ns;
		logic [PARTID_W-1:0]     partid;
		logic [PMG_W-1:0]        pmg;
		logic [USER_W-1:0]       user;
		logic                    ctl_ok;
	} psbrg_red_t;

	typedef struct packed {
		psbrg_exp_t exo;
		psbrg_red_t rdo;
	} psbrg_state_t;

	psbrg_state_t         state_r;
	psbrg_state_t         state_nxt;
	// combinational helpers, none of them state
	psbrg_pkg::psbrg_sp_t exp_sp;
	psbrg_pkg::psbrg_ns_t red_ns;
	logic                 ctl_hit;

	// ==========================================================
	// label expansion, two-space side into four-space side
	// a two-space requester names only secure or nonsecure, so the
	// upper label bit stays clear: root and realm never appear here,
	// and the space the requester chose passes as it was chosen
	always_comb begin
		case (exp_space_label_1bit)
			`PSBRG_NS_SECURE:    exp_sp = `PSBRG_SP_SECURE;
			`PSBRG_NS_NONSECURE: exp_sp = `PSBRG_SP_NONSECURE;
			default:             exp_sp = `PSBRG_SP_SECURE;
		endcase
	end

	// ==========================================================
	// label reduction, four-space side into two-space side
	// secure and nonsecure keep their side in every mode; only root
	// and realm follow the map bits, so a wrong map cannot move a
	// secure request into the nonsecure space or back
	psbrg_reduce u_reduce (
		.sp_in        (red_space_label_2bit),
		.prog_en      (prog_en),
		.map_root_ns  (map_root_ns),
		.map_realm_ns (map_realm_ns),
		.ns_out       (red_ns)
	);

	// ==========================================================
	// control access filter
	// settings of a space are reachable only through that space's own
	// physical address space. a mismatch is still forwarded and only
	// flagged: the completer decides what to do with it, and the
	// bridge never has to hold a request back
	always_comb begin
		case (red_space_label_2bit)
			`PSBRG_SP_SECURE:
				ctl_hit = (red_pas == `PSBRG_SP_SECURE);
			`PSBRG_SP_NONSECURE:
				ctl_hit = (red_pas == `PSBRG_SP_NONSECURE);
			`PSBRG_SP_ROOT:
				ctl_hit = (red_pas == `PSBRG_SP_ROOT);
			`PSBRG_SP_REALM:
				ctl_hit = (red_pas == `PSBRG_SP_REALM);
			default:
				ctl_hit = 1'h0;
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		state_nxt = state_r;
		// expansion path: valid every cycle, fields only with a request,
		// so idle cycles leave the last request's fields standing
		state_nxt.exo.valid = exp_valid;
		if (exp_valid) begin
			state_nxt.exo.addr   = exp_addr;
			state_nxt.exo.pas    = exp_pas;
			state_nxt.exo.sp     = exp_sp;
			state_nxt.exo.partid = exp_partid;
			state_nxt.exo.pmg    = exp_pmg;
			state_nxt.exo.user   = exp_user;
		end
		// reduction path: the ok flag lives only as long as its valid,
		// so a stale grant can never ride on an idle cycle
		state_nxt.rdo.valid  = red_valid;
		state_nxt.rdo.ctl_ok = 1'h0;
		if (red_valid) begin
			state_nxt.rdo.addr   = red_addr;
			state_nxt.rdo.pas    = red_pas;
			state_nxt.rdo.ns     = red_ns;
			state_nxt.rdo.partid = red_partid;
			state_nxt.rdo.pmg    = red_pmg;
			state_nxt.rdo.user   = red_user;
			state_nxt.rdo.ctl_ok = red_ctl_access && ctl_hit;
		end
	end

	// ==========================================================
	// registers
	// the async reset clears every valid, so no stale request leaves
	// the bridge after reset; the data fields clear too, which costs
	// nothing and keeps the outputs quiet until the first request
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// outputs, straight from the state register
	// expansion path
	assign exo_valid            = state_r.exo.valid;
	assign exo_addr             = state_r.exo.addr;
	assign exo_pas              = state_r.exo.pas;
	// four-space side always gets the full two-bit label
	assign exo_space_label_2bit = state_r.exo.sp;
	assign exo_partid           = state_r.exo.partid;
	assign exo_pmg              = state_r.exo.pmg;
	assign exo_user             = state_r.exo.user;

	// reduction path
	assign rdo_valid            = state_r.rdo.valid;
	assign rdo_addr             = state_r.rdo.addr;
	assign rdo_pas              = state_r.rdo.pas;
	assign rdo_space_label_1bit = state_r.rdo.ns;
	assign rdo_partid           = state_r.rdo.partid;
	assign rdo_pmg              = state_r.rdo.pmg;
	assign rdo_user             = state_r.rdo.user;
	assign rdo_ctl_ok           = state_r.rdo.ctl_ok;
endmodule

// ===== dv/psbrg_bridge_monitor.sv
/*
 port checker of the partition space bridge: latency and label mapping.
 assumes it is bound to psbrg_bridge, one clock, reset active low.
*/
`timescale 1ns/1ps
module psbrg_bridge_monitor (
	// clock, reset, mapping
	input wire logic                 sys_clk,
	input wire logic                 resetn,
	input wire logic                 prog_en,
	input wire logic                 map_root_ns,
	input wire logic                 map_realm_ns,
	// expansion path
	input wire logic                 exp_valid,
	input wire psbrg_pkg::psbrg_ns_t exp_space_label_1bit,
	input wire logic                 exo_valid,
	input wire psbrg_pkg::psbrg_sp_t exo_space_label_2bit,
	// reduction path
	input wire logic                 red_valid,
	input wire psbrg_pkg::psbrg_sp_t red_space_label_2bit,
	input wire logic [1:0]           red_pas,
	input wire logic                 red_ctl_access,
	input wire logic                 rdo_valid,
	input wire logic [1:0]           rdo_pas,
	input wire psbrg_pkg::psbrg_ns_t rdo_space_label_1bit,
	input wire logic                 rdo_ctl_ok
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// ==========================================================
	// assertions
	a_exp_fwd: assert property (exp_valid |=> exo_valid)
		else $error("expansion request not forwarded");
	a_exp_label: assert property (exp_valid |=>
		exo_space_label_2bit == {1'h0, $past(exp_space_label_1bit)})
		else $error("expanded label wrong");
	a_red_only: assert property (rdo_valid |-> $past(red_valid))
		else $error("reduced request without cause");
	a_secure_keep: assert property (red_valid &&
		red_space_label_2bit == 2'h0 |=> !rdo_space_label_1bit)
		else $error("secure label altered");
	a_ns_keep: assert property (red_valid &&
		red_space_label_2bit == 2'h1 |=> rdo_valid && rdo_space_label_1bit)
		else $error("nonsecure label altered");
	a_fixed_red: assert property (red_valid && !prog_en |=>
		rdo_space_label_1bit == $past(red_space_label_2bit[0]))
		else $error("fixed reduction wrong");
	a_prog_root: assert property (red_valid && prog_en &&
		red_space_label_2bit == 2'h2 |=>
		rdo_space_label_1bit == $past(map_root_ns))
		else $error("programmed root reduction wrong");
	a_prog_realm: assert property (red_valid && prog_en &&
		red_space_label_2bit == 2'h3 |=>
		rdo_space_label_1bit == $past(map_realm_ns))
		else $error("programmed realm reduction wrong");
	a_pas_pass: assert property (red_valid |=> rdo_pas == $past(red_pas))
		else $error("address space altered");
	a_ctl_match: assert property (rdo_ctl_ok |-> $past(red_valid &&
		red_ctl_access && red_pas == red_space_label_2bit))
		else $error("control access passed in wrong space");
endmodule

// ===== dv/psbrg_completer_model.sv
/*
 two-space completer: counts nonsecure requests it receives.
 assumes the bridge's reduction outputs drive it.
*/
`timescale 1ns/1ps
module psbrg_completer_model (
	// request side
	input  wire logic                 sys_clk,
	input  wire logic                 rdo_valid,
	input  wire psbrg_pkg::psbrg_ns_t rdo_space_label_1bit,
	// statistics
	output int                        n_ns
);
	initial n_ns = 0;
	// sees only the one-bit label, so two spaces at most
	always @(posedge sys_clk) begin
		if (rdo_valid === 1'h1 && rdo_space_label_1bit === 1'h1) n_ns++;
	end
endmodule

// ===== dv/psbrg_bridge_bench.sv
/*
 bench of the partition space bridge: expansion, reduction, control access.
 assumes the design and the checker files are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module psbrg_bridge_bench;
	logic                 sys_clk, resetn, prog_en, map_root_ns, map_realm_ns;
	logic                 exp_valid, exo_valid, red_valid, rdo_valid;
	logic                 red_ctl_access, rdo_ctl_ok;
	logic [47:0]          exp_addr, exo_addr, red_addr, rdo_addr;
	logic [15:0]          exp_partid, exo_partid, red_partid, rdo_partid;
	logic [7:0]           exp_pmg, exo_pmg, red_pmg, rdo_pmg;
	logic [7:0]           exp_user, exo_user, red_user, rdo_user;
	logic [1:0]           exp_pas, exo_pas, red_pas, rdo_pas;
	psbrg_pkg::psbrg_ns_t exp_space_label_1bit, rdo_space_label_1bit;
	psbrg_pkg::psbrg_sp_t exo_space_label_2bit, red_space_label_2bit;
	int                   n_errors, cmp_count, n_ns, n_ns_exp;
	logic                 e;
	psbrg_bridge u_dut (.*);
	psbrg_completer_model u_far (.sys_clk, .rdo_valid, .rdo_space_label_1bit,
		.n_ns);
	// ==========================================================
	// scenarios
	task automatic t_expand();
		for (int i = 0; i < 4; i++) begin
			{exp_valid, exp_space_label_1bit, exp_pas} = {1'h1, i[0], i[1:0]};
			{exp_addr, exp_partid, exp_pmg, exp_user} = {20{i[3:0]}};
			@(posedge sys_clk) #1;
			`CHK("exo_valid", 1'h1, exo_valid)
			`CHK("exo_label", {1'h0, i[0]}, exo_space_label_2bit)
			`CHK("exo_pas", exp_pas, exo_pas)
			`CHK("exo_fields", {exp_addr, exp_partid, exp_pmg, exp_user},
				{exo_addr, exo_partid, exo_pmg, exo_user})
		end
	endtask
	// every label under fixed and programmed mapping, back to back
	task automatic t_reduce();
		for (int i = 0; i < 16; i++) begin
			{map_root_ns, prog_en, red_space_label_2bit} = i[3:0];
			{map_realm_ns, red_pas, red_ctl_access} = {~i[3], i[3:2], 1'h1};
			{red_valid, red_addr, red_partid, red_pmg, red_user} = {1'h1, {20{i[3:0]}}};
			e = (i[1] && prog_en) ? (i[0] ? map_realm_ns : map_root_ns) : i[0];
			n_ns_exp += e;
			@(posedge sys_clk) #1;
			`CHK("rdo_label", e, rdo_space_label_1bit)
			`CHK("rdo_pas", red_pas, rdo_pas)
			`CHK("rdo_ctl_ok", i[3:2] == i[1:0], rdo_ctl_ok)
			`CHK("rdo_fields", {1'h1, red_addr, red_partid, red_pmg, red_user},
				{rdo_valid, rdo_addr, rdo_partid, rdo_pmg, rdo_user})
		end
	endtask
	// a second reset in mid-run, with requests standing throughout
	task automatic t_reset();
		{exp_valid, exp_space_label_1bit, red_valid} = 3'h7;
		{red_space_label_2bit, red_pas, prog_en} = 5'h0;
		@(posedge sys_clk) #1;
		`CHK("pre_rst", 3'h7, {exo_valid, rdo_valid, rdo_ctl_ok})
		resetn = 1'h0;
		#1;
		`CHK("rst_clear", 4'h0, {exo_valid, exo_space_label_2bit, rdo_valid})
		@(posedge sys_clk) #1;
		`CHK("rst_hold", 3'h0, {exo_valid, rdo_valid, rdo_ctl_ok})
		resetn = 1'h1;
		@(posedge sys_clk) #1;
		`CHK("post_rst_label", 2'h1, exo_space_label_2bit)
		`CHK("post_rst", 3'h7, {exo_valid, rdo_valid, rdo_ctl_ok})
	endtask
	task automatic t_idle();
		{exp_valid, red_valid} = 2'h0;
		@(posedge sys_clk) #1;
		`CHK("idle_valid", 3'h0, {exo_valid, rdo_valid, rdo_ctl_ok})
		`CHK("far_ns_count", n_ns_exp, n_ns)
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ==========================================================
	// clock, reset, sequence, watchdog
	initial begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		{resetn, prog_en, map_root_ns, map_realm_ns, red_ctl_access} = 5'h0;
		{exp_valid, exp_addr, exp_pas, exp_space_label_1bit} = '0;
		{exp_partid, exp_pmg, exp_user, red_valid, red_addr, red_pas} = '0;
		{red_space_label_2bit, red_partid, red_pmg, red_user} = '0;
		{n_errors, cmp_count, n_ns_exp} = '0;
		repeat (6) @(posedge sys_clk);
		#1 resetn = 1'h1;
		t_expand();
		t_reduce();
		t_reset();
		t_idle();
		finish_test();
	end
	initial begin
		#2000;
		n_errors++;
		finish_test();
	end
endmodule
bind psbrg_bridge psbrg_bridge_monitor u_mon (.sys_clk, .resetn, .prog_en,
	.map_root_ns, .map_realm_ns, .exp_valid, .exp_space_label_1bit,
	.exo_valid, .exo_space_label_2bit, .red_valid, .red_space_label_2bit,
	.red_pas, .red_ctl_access, .rdo_valid, .rdo_pas, .rdo_space_label_1bit,
	.rdo_ctl_ok);
